/* pkg/ougic_map.svh */
`ifndef OUGIC_MAP_SVH
`define OUGIC_MAP_SVH
`define OUGIC_CFG_NIB   4'h8
`define OUGIC_A_PEND    8'h80
`define OUGIC_A_SRC_LO  8'h81
`define OUGIC_A_SRC_MI  8'h82
`define OUGIC_A_SRC_HI  8'h83
`define OUGIC_A_TCMD    8'h84
`define OUGIC_A_TRSV    8'h85
`define OUGIC_A_TCNT_LO 8'h86
`define OUGIC_A_TCNT_HI 8'h87
`define OUGIC_A_EIGHTX  8'h88
`define OUGIC_A_FOURX   8'h89
`define OUGIC_A_SRST    8'h8A
`define OUGIC_A_SLEEP   8'h8B
`define OUGIC_A_REV     8'h8C
`define OUGIC_A_PARTID  8'h8D
`define OUGIC_A_BCAST   8'h8E
`define OUGIC_CH_ISR    4'h2
`define OUGIC_CH_LSR    4'h5
`define OUGIC_CH_MSR    4'h6
`define OUGIC_RST_BYTE  8'h00
`define OUGIC_ALL_CH    8'hFF
`define OUGIC_SRC_NONE  3'h0
`define OUGIC_SRC_RX    3'h1
`define OUGIC_SRC_TOUT  3'h2
`define OUGIC_SRC_TX    3'h3
`define OUGIC_SRC_MDM   3'h4
`define OUGIC_SRC_TMR   3'h7
`define OUGIC_TC_INT_ON  4'h1
`define OUGIC_TC_INT_OFF 4'h2
`define OUGIC_TC_ONESHOT 4'h3
`define OUGIC_TC_RETRIG  4'h4
`define OUGIC_TC_INTCLK  4'h5
`define OUGIC_TC_EXTCLK  4'h6
`define OUGIC_TC_START   4'h9
`define OUGIC_TC_STOP    4'hA
`define OUGIC_TC_RESET   4'hB
`endif

/* pkg/ougic_pkg.sv */
package ougic_pkg;
  typedef logic [2:0] ougic_src_t;
  typedef logic [7:0] ougic_byte_t;
endpackage : ougic_pkg

/* rtl/ougic_top.sv */
// Functional notes
// - Config registers decoded at 0x80 to 0x8F
// - Channel windows selected by upper address nibble
// - First eight channel registers use legacy layout
// - Global block: status, timer, sampling, sleep, reset
// - Four interrupt registers read zero after reset
// - Channel enable gates every channel source except timer and wake-up
// - Pending bit N set while channel N requests
// - Pending clears on status, line, modem reads
// - Three bytes hold 3-bit code per channel
// - Code zero when none or only wake-up
// - Code 1: receive ready or line error OR
// - Receive ready clears below trigger; errors on read
// - Code 2: receive time-out, clears like ready
// - Code 3: transmit empty, clears on status read
// - Code 4: modem change or flow character detect
// - Code 7 timer only channel 0, read clears
// - Lowest non-zero code wins priority
// - Timer and wake masked by global registers
// - Wake interrupt only after all eight slept
// - Soft reset bits reset channel, self-clear
// - Broadcast bit writes all eight channels
`timescale 1ns/100ps
`default_nettype none
`include "ougic_map.svh"
module ougic_top
  import ougic_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] PART_ID  = 8'h5A  // Arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        bus_cs_n,
  input  wire logic        bus_rd_n,
  input  wire logic        bus_wr_n,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_data_in,
  output logic      [7:0]  bus_data_out,
  output logic             bus_data_oe,
  output logic             irq,
  input  wire logic [7:0]  ch_rx_ready,
  input  wire logic [7:0]  ch_rx_timeout,
  input  wire logic [31:0] ch_lsr_err,
  input  wire logic [7:0]  ch_tx_empty,
  input  wire logic [7:0]  ch_modem_delta,
  input  wire logic [7:0]  ch_flow_char,
  input  wire logic [31:0] ch_int_enable,
  input  wire logic [7:0]  ch_wake,
  input  wire logic        timer_timeout,
  input  wire logic [7:0]  chan_rd_data,
  output logic      [7:0]  chan_wr_en,
  output logic      [7:0]  chan_rd_en,
  output logic      [3:0]  chan_addr,
  output logic      [7:0]  chan_wr_data,
  output logic      [7:0]  chan_soft_rst,
  output logic      [7:0]  eightx_sel,
  output logic      [7:0]  fourx_sel,
  output logic      [7:0]  sleep_en,
  output logic      [15:0] timer_count,
  output logic             timer_int_en,
  output logic             timer_oneshot,
  output logic             timer_ext_clk,
  output logic             timer_run,
  output logic             timer_restart
);

  function automatic ougic_src_t src_code(input logic rx, input logic tout,
                                          input logic tx, input logic mdm,
                                          input logic tmr);
    if (rx)        src_code = `OUGIC_SRC_RX;
    else if (tout) src_code = `OUGIC_SRC_TOUT;
    else if (tx)   src_code = `OUGIC_SRC_TX;
    else if (mdm)  src_code = `OUGIC_SRC_MDM;
    else if (tmr)  src_code = `OUGIC_SRC_TMR;
    else           src_code = `OUGIC_SRC_NONE;
  endfunction : src_code

  // Host pins are asynchronous; two flops before use
  logic [18:0] pin_s1_q;
  logic [18:0] pin_s2_q;
  logic        rd_prev_q;
  logic        wr_prev_q;
  logic        rd_act;
  logic        wr_act;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1_q  <= 19'h7_0000;
      pin_s2_q  <= 19'h7_0000;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      pin_s1_q  <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
      pin_s2_q  <= pin_s1_q;
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  logic [7:0] addr_s;
  logic [7:0] wdat_s;
  logic       rd_go;
  logic       wr_go;
  logic       is_cfg;
  logic [7:0] ch_hit;
  assign rd_act = !pin_s2_q[18] && !pin_s2_q[17];
  assign wr_act = !pin_s2_q[18] && !pin_s2_q[16];
  assign addr_s = pin_s2_q[15:8];
  assign wdat_s = pin_s2_q[7:0];
  // Read acts at strobe start; write acts at strobe end, data settled
  assign rd_go  = rd_act && !rd_prev_q;
  assign wr_go  = !wr_act && wr_prev_q;
  assign is_cfg = addr_s[7:4] == `OUGIC_CFG_NIB;
  assign ch_hit = addr_s[7] ? 8'h00 : 8'h01 << addr_s[6:4];

  logic [7:0] isr_rd;
  logic [7:0] lsr_rd;
  logic [7:0] msr_rd;
  logic       tcmd_rd;
  // Read side effect of one channel register offset
  function automatic ougic_byte_t ch_reg_rd(input logic go, input logic [3:0] off,
                                            input logic [7:0] a, input ougic_byte_t hit);
    ch_reg_rd = (go && a[3:0] == off) ? hit : 8'h00;
  endfunction : ch_reg_rd

  always_comb begin
    // channel offsets follow the legacy eight-register layout
    isr_rd  = ch_reg_rd(rd_go, `OUGIC_CH_ISR, addr_s, ch_hit);
    lsr_rd  = ch_reg_rd(rd_go, `OUGIC_CH_LSR, addr_s, ch_hit);
    msr_rd  = ch_reg_rd(rd_go, `OUGIC_CH_MSR, addr_s, ch_hit);
    tcmd_rd = rd_go && addr_s == `OUGIC_A_TCMD;
  end

  // Global configuration registers
  logic [7:0] bcast_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      eightx_sel  <= `OUGIC_RST_BYTE;
      fourx_sel   <= `OUGIC_RST_BYTE;
      sleep_en    <= `OUGIC_RST_BYTE;
      timer_count <= {`OUGIC_RST_BYTE, `OUGIC_RST_BYTE};
      bcast_q     <= `OUGIC_RST_BYTE;
    end else if (wr_go) begin
      case (addr_s)
        `OUGIC_A_EIGHTX:  eightx_sel <= wdat_s;
        `OUGIC_A_FOURX:   fourx_sel <= wdat_s;
        `OUGIC_A_SLEEP:   sleep_en <= wdat_s;
        `OUGIC_A_TCNT_LO: timer_count[7:0] <= wdat_s;
        `OUGIC_A_TCNT_HI: timer_count[15:8] <= wdat_s;
        `OUGIC_A_BCAST:   bcast_q <= {7'h00, wdat_s[0]};
        default: ;
      endcase
    end
  end

  // Timer commands are self-clearing; only their effects are held
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer_int_en  <= 1'b0;
      timer_oneshot <= 1'b0;
      timer_ext_clk <= 1'b0;
      timer_run     <= 1'b0;
      timer_restart <= 1'b0;
    end else begin
      timer_restart <= 1'b0;
      if (wr_go && addr_s == `OUGIC_A_TCMD) begin
        case (wdat_s[3:0])
          `OUGIC_TC_INT_ON:  timer_int_en <= 1'b1;
          `OUGIC_TC_INT_OFF: timer_int_en <= 1'b0;
          `OUGIC_TC_ONESHOT: timer_oneshot <= 1'b1;
          `OUGIC_TC_RETRIG:  timer_oneshot <= 1'b0;
          `OUGIC_TC_INTCLK:  timer_ext_clk <= 1'b0;
          `OUGIC_TC_EXTCLK:  timer_ext_clk <= 1'b1;
          `OUGIC_TC_START:   timer_run <= 1'b1;
          `OUGIC_TC_STOP:    timer_run <= 1'b0;
          `OUGIC_TC_RESET:   timer_restart <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Channel access strobes and soft reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      chan_wr_en    <= 8'h00;
      chan_rd_en    <= 8'h00;
      chan_addr     <= 4'h0;
      chan_wr_data  <= 8'h00;
      chan_soft_rst <= 8'h00;
    end else begin
      chan_addr    <= addr_s[3:0];
      chan_wr_data <= wdat_s;
      chan_rd_en   <= rd_go ? ch_hit : 8'h00;
      if (wr_go && !addr_s[7])
        chan_wr_en <= bcast_q[0] ? `OUGIC_ALL_CH : ch_hit;
      else
        chan_wr_en <= 8'h00;
      // One-cycle pulse per written one
      chan_soft_rst <= (wr_go && addr_s == `OUGIC_A_SRST) ? wdat_s : 8'h00;
    end
  end

  // Sleep tracking for the wake-up indication
  logic       all_slept_q;
  logic [7:0] wake_q;
  logic [7:0] pend_c;
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      all_slept_q <= 1'b0;
    // Leaving full sleep disarms the wake-up, so a later wake stays quiet
    else if (|ch_wake || sleep_en != `OUGIC_ALL_CH)
      all_slept_q <= 1'b0;
    else if (sleep_en == `OUGIC_ALL_CH && pend_c == 8'h00)
      all_slept_q <= 1'b1;
  end

  logic       tmr_q;
  logic [7:0] lerr_q;
  logic [7:0] tx_q;
  logic [7:0] mdm_q;
  logic [7:0] flow_q;
  logic [7:0] tx_prev_q;
  logic [7:0] mdm_prev_q;
  logic [7:0] flow_prev_q;
  logic [7:0] lerr_prev_q;
  logic [7:0] lerr_in;
  logic [23:0] src_c;

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      tmr_q <= 1'b0;
    else if (timer_timeout && timer_int_en)
      tmr_q <= 1'b1;
    else if (tcmd_rd || chan_soft_rst[0])
      tmr_q <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_prev_q   <= 8'h00;
      mdm_prev_q  <= 8'h00;
      flow_prev_q <= 8'h00;
      lerr_prev_q <= 8'h00;
    end else begin
      tx_prev_q   <= ch_tx_empty;
      mdm_prev_q  <= ch_modem_delta;
      flow_prev_q <= ch_flow_char;
      lerr_prev_q <= lerr_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ch
      logic [3:0] ien;
      logic       rx_src;
      logic       to_src;
      assign ien     = ch_int_enable[4*gi +: 4];
      assign lerr_in[gi] = |ch_lsr_err[4*gi +: 4];
      // Level sources follow the FIFO level
      assign rx_src  = ien[0] && ch_rx_ready[gi];
      assign to_src  = ien[0] && ch_rx_timeout[gi];

      // Sticky sources: set wins over a clear in the same cycle
      always_ff @(posedge sys_clk) begin
        if (!rstn || chan_soft_rst[gi]) begin
          lerr_q[gi] <= 1'b0;
          tx_q[gi]   <= 1'b0;
          mdm_q[gi]  <= 1'b0;
          flow_q[gi] <= 1'b0;
          wake_q[gi] <= 1'b0;
        end else begin
          if (ien[2] && lerr_in[gi] && !lerr_prev_q[gi])
            lerr_q[gi] <= 1'b1;
          else if (lsr_rd[gi])
            lerr_q[gi] <= 1'b0;
          if (ien[1] && ch_tx_empty[gi] && !tx_prev_q[gi])
            tx_q[gi] <= 1'b1;
          else if (isr_rd[gi])
            tx_q[gi] <= 1'b0;
          if (ien[3] && ch_modem_delta[gi] && !mdm_prev_q[gi])
            mdm_q[gi] <= 1'b1;
          else if (msr_rd[gi])
            mdm_q[gi] <= 1'b0;
          if (ien[3] && ch_flow_char[gi] && !flow_prev_q[gi])
            flow_q[gi] <= 1'b1;
          else if (isr_rd[gi])
            flow_q[gi] <= 1'b0;
          if (all_slept_q && ch_wake[gi] && sleep_en[gi])
            wake_q[gi] <= 1'b1;
          else if (isr_rd[gi])
            wake_q[gi] <= 1'b0;
        end
      end

      assign src_c[3*gi +: 3] = src_code(rx_src || lerr_q[gi], to_src,
                                         tx_q[gi], mdm_q[gi] || flow_q[gi],
                                         gi == 0 && tmr_q);
      // Wake-up alone still requests service, with code zero
      assign pend_c[gi] = (src_c[3*gi +: 3] != `OUGIC_SRC_NONE) || wake_q[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |pend_c;
  end

  // Channel data is taken a cycle late, once chan_addr carries the new offset
  logic rd_chan_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      rd_chan_q <= 1'b0;
    else
      rd_chan_q <= rd_go && !is_cfg;
  end

  // Read data is captured near strobe start and held through the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_data_out <= 8'h00;
      bus_data_oe  <= 1'b0;
    end else begin
      bus_data_oe <= rd_act;
      if (rd_chan_q) begin
        bus_data_out <= chan_rd_data;
      end else begin
        if (rd_go && is_cfg) begin
          case (addr_s)
            `OUGIC_A_PEND:    bus_data_out <= pend_c;
            `OUGIC_A_SRC_LO:  bus_data_out <= src_c[7:0];
            `OUGIC_A_SRC_MI:  bus_data_out <= src_c[15:8];
            `OUGIC_A_SRC_HI:  bus_data_out <= src_c[23:16];
            `OUGIC_A_TCMD:    bus_data_out <= {7'h00, tmr_q};
            `OUGIC_A_TCNT_LO: bus_data_out <= timer_count[7:0];
            `OUGIC_A_TCNT_HI: bus_data_out <= timer_count[15:8];
            `OUGIC_A_EIGHTX:  bus_data_out <= eightx_sel;
            `OUGIC_A_FOURX:   bus_data_out <= fourx_sel;
            `OUGIC_A_SLEEP:   bus_data_out <= sleep_en;
            `OUGIC_A_REV:     bus_data_out <= REV_CODE;
            `OUGIC_A_PARTID:  bus_data_out <= PART_ID;
            `OUGIC_A_BCAST:   bus_data_out <= bcast_q;
            default:          bus_data_out <= 8'h00;
          endcase
        end
      end
    end
  end

endmodule : ougic_top
`default_nettype wire

/* tb/ougic_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module ougic_top_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        bus_cs_n,
  input wire logic        bus_rd_n,
  input wire logic [7:0]  bus_addr,
  input wire logic        bus_data_oe,
  input wire logic        irq,
  input wire logic [7:0]  ch_rx_ready,
  input wire logic [31:0] ch_int_enable,
  input wire logic [7:0]  chan_wr_en,
  input wire logic [7:0]  chan_rd_en,
  input wire logic [3:0]  chan_addr,
  input wire logic [7:0]  chan_soft_rst,
  input wire logic        timer_restart
);
  logic [7:0] rx_on;
  for (genvar n = 0; n < 8; n++) begin : g_on
    assign rx_on[n] = ch_rx_ready[n] & ch_int_enable[4*n];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_IRQ_RX: assert property (|rx_on |-> ##[1:4] irq)
    else $error("irq missing for enabled source");
  AST_RST_QUIET: assert property (rstn && !$past(rstn) |-> !irq && !bus_data_oe)
    else $error("outputs active after reset");
  AST_OE_IDLE: assert property ((bus_cs_n | bus_rd_n) [*6] |-> !bus_data_oe)
    else $error("data driven without read");
  AST_OE_RD: assert property ((!bus_cs_n && !bus_rd_n) [*4] |-> bus_data_oe)
    else $error("data not driven during read");
  AST_WR_MAP: assert property (|chan_wr_en |-> !bus_addr[7] && chan_addr == bus_addr[3:0]
    && (chan_wr_en == (8'h01 << bus_addr[6:4]) || chan_wr_en == 8'hFF))
    else $error("channel write decode wrong");
  AST_WR_ONE: assert property (|chan_wr_en |=> chan_wr_en == 8'h00)
    else $error("channel write longer than a cycle");
  AST_RD_MAP: assert property (|chan_rd_en |-> !bus_addr[7] && chan_addr == bus_addr[3:0]
    && chan_rd_en == (8'h01 << bus_addr[6:4]) ##1 chan_rd_en == 8'h00)
    else $error("channel read decode wrong");
  AST_SRST_ONE: assert property ($rose(|chan_soft_rst) |=> !(|chan_soft_rst))
    else $error("soft reset not self clearing");
  AST_RESTART: assert property (timer_restart |=> !timer_restart)
    else $error("timer restart not a pulse");
endmodule : ougic_top_asserts
bind ougic_top ougic_top_asserts u_asserts (.sys_clk, .rstn, .bus_cs_n, .bus_rd_n, .bus_addr,
  .bus_data_oe, .irq, .ch_rx_ready, .ch_int_enable, .chan_wr_en, .chan_rd_en, .chan_addr,
  .chan_soft_rst, .timer_restart);
`default_nettype wire

/* tb/ougic_chan_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ougic_chan_model (
  input wire logic         sys_clk,
  input wire logic         rstn,
  input wire logic [7:0]   chan_rd_en,
  input wire logic [3:0]   chan_addr,
  input wire logic [7:0]   err_set,
  output logic     [7:0]   chan_rd_data,
  output logic     [31:0]  ch_lsr_err
);
  logic [7:0] err_q;
  // Offset echoed back so the bench can tell which register answered
  assign chan_rd_data = {4'hC, chan_addr};
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      err_q <= 8'h00;
    end else begin
      err_q <= (err_q & ~(chan_addr == 4'h5 ? chan_rd_en : 8'h00)) | err_set;
    end
  end
  for (genvar n = 0; n < 8; n++) begin : g_err
    assign ch_lsr_err[4*n +: 4] = {3'h0, err_q[n]};
  end
endmodule : ougic_chan_model
`default_nettype wire

/* tb/tb_octal_uart_global_interrupt_config.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_octal_uart_global_interrupt_config;
  import ougic_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, timer_timeout = 1'b0, rst_seen = 1'b0;
  logic        bus_cs_n = 1'b1, bus_rd_n = 1'b1, bus_wr_n = 1'b1;
  ougic_byte_t bus_addr = '0, bus_data_in = '0, ch_rx_ready = '0, ch_rx_timeout = '0;
  ougic_byte_t ch_tx_empty = '0, ch_modem_delta = '0, ch_flow_char = '0, ch_wake = '0;
  ougic_byte_t err_set = '0, srst_seen = '0, wr_seen = '0, wd_seen = '0;
  logic [31:0] ch_int_enable = '0, ch_lsr_err;
  logic [7:0]  bus_data_out, chan_rd_data, chan_wr_en, chan_rd_en, chan_wr_data, chan_soft_rst;
  logic [7:0]  eightx_sel, fourx_sel, sleep_en;
  logic [3:0]  chan_addr;
  logic [15:0] timer_count;
  logic        bus_data_oe, irq, timer_int_en, timer_oneshot, timer_ext_clk, timer_run;
  logic        timer_restart;
  int          fails = 0, cmp_count = 0;
  ougic_byte_t ro[4] = '{8'h80, 8'h85, 8'h8D, 8'h8F};
  ougic_byte_t rwa[5] = '{8'h86, 8'h87, 8'h88, 8'h89, 8'h8B};
  ougic_byte_t rwv[5] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0, 8'h81};
  ougic_byte_t clr[6] = '{8'h22, 8'h36, 8'h42, 8'h52, 8'h65, 8'h76};
  logic [3:0]  on_c[4] = '{4'h1, 4'h3, 4'h6, 4'h9};
  logic [3:0]  off_c[4] = '{4'h2, 4'h4, 4'h5, 4'hA};
  ougic_top dut (.sys_clk, .rstn, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_addr, .bus_data_in,
    .bus_data_out, .bus_data_oe, .irq, .ch_rx_ready, .ch_rx_timeout, .ch_lsr_err, .ch_tx_empty,
    .ch_modem_delta, .ch_flow_char, .ch_int_enable, .ch_wake, .timer_timeout, .chan_rd_data,
    .chan_wr_en, .chan_rd_en, .chan_addr, .chan_wr_data, .chan_soft_rst, .eightx_sel,
    .fourx_sel, .sleep_en, .timer_count, .timer_int_en, .timer_oneshot, .timer_ext_clk,
    .timer_run, .timer_restart);
  ougic_chan_model u_chan (.sys_clk, .rstn, .chan_rd_en, .chan_addr, .err_set,
    .chan_rd_data, .ch_lsr_err);
  always #2 sys_clk = ~sys_clk;
  // Pulses are caught here, the tasks would miss them between strobes
  always @(posedge sys_clk) begin
    if (|chan_soft_rst) srst_seen <= chan_soft_rst;
    if (|chan_wr_en) wr_seen <= chan_wr_en;
    if (|chan_wr_en) wd_seen <= chan_wr_data;
    if (timer_restart) rst_seen <= 1'b1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes stay long because the design synchronises them over two flops
  task automatic wr(input ougic_byte_t a, input ougic_byte_t d);
    bus_addr <= a;
    bus_data_in <= d;
    bus_cs_n <= 1'b0;
    bus_wr_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus_cs_n <= 1'b1;
    bus_wr_n <= 1'b1;
    repeat (7) @(posedge sys_clk);
  endtask : wr
  task automatic rd(input ougic_byte_t a, output ougic_byte_t v);
    bus_addr <= a;
    bus_cs_n <= 1'b0;
    bus_rd_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 v = bus_data_out;
    @(posedge sys_clk);
    bus_cs_n <= 1'b1;
    bus_rd_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : rd
  task automatic rdchk(input ougic_byte_t a, input ougic_byte_t e);
    ougic_byte_t v;
    rd(a, v);
    chk({16'h0000, v}, {16'h0000, e});
  endtask : rdchk
  task automatic chk_int(input ougic_byte_t p, input logic [23:0] s);
    ougic_byte_t b0, b1, b2;
    rdchk(8'h80, p);
    rd(8'h81, b0);
    rd(8'h82, b1);
    rd(8'h83, b2);
    chk({b2, b1, b0}, s);
    chk({23'h0, irq}, {23'h0, |p});
  endtask : chk_int
  task automatic kick(input logic t, input ougic_byte_t w);
    timer_timeout <= t;
    ch_wake <= w;
    @(posedge sys_clk);
    timer_timeout <= 1'b0;
    ch_wake <= 8'h00;
    repeat (4) @(posedge sys_clk);
  endtask : kick
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 2; k++) begin
      for (int a = 0; a < 16; a++) begin
        rdchk(8'h80 + 8'(a), a == 12 ? 8'h01 : a == 13 ? 8'h5A : 8'h00);
      end
      foreach (ro[i]) wr(ro[i], 8'hAA);
    end
    done("map");
    foreach (rwa[i]) wr(rwa[i], rwv[i]);
    foreach (rwa[i]) rdchk(rwa[i], rwv[i]);
    chk({eightx_sel, fourx_sel, sleep_en}, 24'h0F_F081);
    chk({8'h00, timer_count}, 24'h00_3CA5);
    wr(8'h8E, 8'hFF);
    rdchk(8'h8E, 8'h01);
    wr(8'h13, 8'h77);
    chk({8'h00, wr_seen, wd_seen}, 24'h00_FF77);
    wr(8'h8E, 8'h00);
    wr(8'h13, 8'h66);
    chk({8'h00, wr_seen, wd_seen}, 24'h00_0266);
    done("registers");
    foreach (on_c[i]) wr(8'h84, {4'h0, on_c[i]});
    chk({20'h0_0000, timer_int_en, timer_oneshot, timer_ext_clk, timer_run}, 24'h00_000F);
    kick(1'b1, 8'h00);
    chk_int(8'h01, 24'h00_0007);
    rdchk(8'h84, 8'h01);
    rdchk(8'h84, 8'h00);
    chk_int(8'h00, 24'h00_0000);
    foreach (off_c[i]) wr(8'h84, {4'h0, off_c[i]});
    chk({20'h0_0000, timer_int_en, timer_oneshot, timer_ext_clk, timer_run}, 24'h00_0000);
    kick(1'b1, 8'h00);
    chk_int(8'h00, 24'h00_0000);
    wr(8'h84, 8'h0B);
    chk({23'h0, rst_seen}, 24'h00_0001);
    done("timer");
    ch_int_enable <= 32'hFFFF_FF0F;
    @(posedge sys_clk);
    ch_rx_ready <= 8'h11;
    ch_rx_timeout <= 8'h92;
    ch_tx_empty <= 8'h14;
    ch_modem_delta <= 8'h88;
    ch_flow_char <= 8'h20;
    err_set <= 8'h40;
    @(posedge sys_clk);
    err_set <= 8'h00;
    repeat (4) @(posedge sys_clk);
    chk_int(8'hFD, {3'h2, 3'h1, 3'h4, 3'h1, 3'h4, 3'h3, 3'h0, 3'h1});
    ch_rx_ready <= 8'h00;
    ch_rx_timeout <= 8'h00;
    ch_tx_empty <= 8'h00;
    ch_modem_delta <= 8'h00;
    ch_flow_char <= 8'h00;
    repeat (4) @(posedge sys_clk);
    chk_int(8'hFC, {3'h4, 3'h1, 3'h4, 3'h3, 3'h4, 3'h3, 3'h0, 3'h0});
    foreach (clr[i]) rdchk(clr[i], {4'hC, clr[i][3:0]});
    chk_int(8'h00, 24'h00_0000);
    done("sources");
    wr(8'h8B, 8'hFF);
    kick(1'b0, 8'h08);
    chk_int(8'h08, 24'h00_0000);
    rdchk(8'h32, 8'hC2);
    chk_int(8'h00, 24'h00_0000);
    wr(8'h8B, 8'h0F);
    kick(1'b0, 8'h28);
    chk_int(8'h00, 24'h00_0000);
    wr(8'h8A, 8'h24);
    chk({16'h0000, srst_seen}, 24'h00_0024);
    rdchk(8'h8A, 8'h00);
    done("sleep and reset");
    summarize();
  end
endmodule : tb_octal_uart_global_interrupt_config
`default_nettype wire
